// [src/amp_mode_protect_ctrl.sv]
/*
 * Mode control, turn-on sequencing and output protection of a switching stereo amplifier,
 * with an AXI4-Lite register slave and a level interrupt.
 * Assumes analog comparators arrive as asynchronous levels and audio duty on mclk.
 */
`timescale 1ns/1ns
module amp_mode_protect_ctrl
    import amp_pkg::*;
#(
    parameter int CYC_PER_MS = CYC_PER_MS_DEF,
    parameter int TURN_MS = TURN_ON_MS,
    parameter int HOLD_MS = FAULT_HOLD_MS,
    parameter int PWM_PERIOD = PWM_PERIOD_DEF
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic headphone_sense_input,
    input wire logic supply_under_voltage,
    input wire logic soa_fault,
    input wire logic temp_above_upper,
    input wire logic temp_below_lower,
    input wire logic [DUTY_W-1:0] audio_duty,
    output logic gate_drive_en,
    output logic speaker_en,
    output logic headphone_en,
    output logic audio_mute,
    output logic low_power,
    output logic pwm_out_p,
    output logic pwm_out_n,
    output logic irq
);
    localparam int TMR_W = 10;
    localparam int MS_W = $clog2(CYC_PER_MS + 1);
    localparam logic [MS_W-1:0] MS_LAST = MS_W'(CYC_PER_MS - 1);
    localparam logic [TMR_W-1:0] TURN_LAST = TMR_W'(TURN_MS - 1);
    localparam logic [TMR_W-1:0] HOLD_LAST = TMR_W'(HOLD_MS - 1);

    generate
        if (CYC_PER_MS < 1 || TURN_MS < 1 || HOLD_MS < 1 ||
                TURN_MS >= (1 << TMR_W) || HOLD_MS >= (1 << TMR_W)) begin : g_chk
            $error("amp_mode_protect_ctrl timing parameters out of range");
        end
    endgenerate

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFS_MODE) || (a == OFS_CBYTE) || (a == OFS_STATUS) ||
            (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
    endfunction

    // Asynchronous sense levels.
    // Every comparator level crosses two flip-flops before any logic reads it.
    sense_t raw;
    sense_t sns;
    assign raw = '{hp_sense: headphone_sense_input, uv: supply_under_voltage,
        fault: soa_fault, temp_hi: temp_above_upper, temp_below_lo: temp_below_lower};

    sync_bits #(
        .W($bits(sense_t))
    ) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din(raw),
        .dout(sns)
    );

    // Millisecond tick for the long timers.
    // The divider runs freely, so each delay lands between N-1 and N ticks.
    logic [MS_W-1:0] ms_cnt_r;
    wire ms_tick = ms_cnt_r == MS_LAST;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
        end
    end

    // Register bus: write address and data are captured independently.
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [MODE_W-1:0] mode_r;
    logic [EV_W-1:0] irq_stat_r;
    logic [EV_W-1:0] irq_mask_r;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    wire aw_held_nxt = (aw_held_r || aw_take) && !wr_fire;
    wire w_held_nxt = (w_held_r || w_take) && !wr_fire;
    wire wr_ok = wr_fire && is_mapped(awaddr_r);
    wire wr_lane0 = wr_ok && wstrb_r[0];
    wire wr_mode = wr_lane0 && (awaddr_r == OFS_MODE);
    wire wr_cbyte = wr_lane0 && (awaddr_r == OFS_CBYTE) && !wdata_r[CBYTE_SEL_BIT];
    wire wr_stat = wr_lane0 && (awaddr_r == OFS_IRQ_STAT);
    wire wr_mask = wr_lane0 && (awaddr_r == OFS_IRQ_MASK);
    wire bvalid_nxt = wr_fire || (s_axi_bvalid && !s_axi_bready);

    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            s_axi_awready <= !aw_held_nxt;
            s_axi_wready <= !w_held_nxt;
            s_axi_bvalid <= bvalid_nxt;
            if (wr_fire) begin
                s_axi_bresp <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Mode register: both bits clear at reset, so the part wakes shut down and muted.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mode_r <= MODE_RESET;
        end else if (wr_mode || wr_cbyte) begin
            mode_r <= wdata_r[MODE_W-1:0];
        end
    end

    // Sequencer.
    // Under-voltage parks the sequencer in turn-on, so the delay restarts on recovery.
    amp_state_t state_r;
    amp_state_t state_nxt;
    logic [TMR_W-1:0] tmr_r;
    logic therm_r;
    logic uv_q_r;
    wire run_req = mode_r[MODE_RUN_BIT];
    wire unmute_req = mode_r[MODE_UNMUTE_BIT];
    wire turn_done = (state_r == ST_TURNON) && ms_tick && (tmr_r == TURN_LAST);
    wire hold_done = (state_r == ST_FAULT) && ms_tick && (tmr_r == HOLD_LAST);
    wire therm_nxt = sns.temp_hi || (therm_r && !sns.temp_below_lo);

    always_comb begin
        state_nxt = state_r;
        if (!run_req) begin
            state_nxt = ST_SHDN;
        end else if (sns.uv) begin
            state_nxt = ST_TURNON;
        end else begin
            case (state_r)
                ST_SHDN: begin
                    state_nxt = ST_TURNON;
                end
                ST_TURNON: begin
                    if (turn_done) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (sns.fault) begin
                        state_nxt = ST_FAULT;
                    end
                end
                ST_FAULT: begin
                    if (hold_done) begin
                        state_nxt = ST_RUN;
                    end
                end
                default: begin
                    state_nxt = ST_SHDN;
                end
            endcase
        end
    end

    // The timer restarts on every state change, including each new fault entry.
    wire tmr_clr = (state_nxt != state_r) || sns.uv;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= ST_SHDN;
            tmr_r <= '0;
            therm_r <= 1'b0;
            uv_q_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            therm_r <= therm_nxt;
            uv_q_r <= sns.uv;
            if (tmr_clr) begin
                tmr_r <= '0;
            end else if (ms_tick) begin
                tmr_r <= tmr_r + 1'b1;
            end
        end
    end

    // Output drive, all registered.
    // Mute follows the sequencer too, so turn-on and shutdown stay silent.
    wire in_run = state_nxt == ST_RUN;
    wire drive_nxt = in_run && !therm_nxt && !sns.uv;
    wire spk_nxt = drive_nxt && !sns.hp_sense;
    wire mute_nxt = !unmute_req || (state_nxt == ST_SHDN) || (state_nxt == ST_TURNON);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gate_drive_en <= 1'b0;
            speaker_en <= 1'b0;
            headphone_en <= 1'b1;
            audio_mute <= 1'b1;
            low_power <= 1'b1;
        end else begin
            gate_drive_en <= drive_nxt;
            speaker_en <= spk_nxt;
            headphone_en <= 1'b1;
            audio_mute <= mute_nxt;
            low_power <= state_nxt == ST_SHDN;
        end
    end

    // Switching runs only while the speaker stage is driven.
    pwm_gen #(
        .PERIOD(PWM_PERIOD),
        .MAX_PCT(DUTY_MAX_PCT)
    ) u_pwm (
        .mclk(mclk),
        .nrst(nrst),
        .run(speaker_en),
        .duty_in(audio_duty),
        .out_p(pwm_out_p),
        .out_n(pwm_out_n)
    );

    // Interrupt status: a new event wins over a simultaneous clear.
    logic [EV_W-1:0] ev;
    assign ev[EV_FAULT] = (state_r == ST_RUN) && (state_nxt == ST_FAULT);
    assign ev[EV_THERM] = therm_nxt && !therm_r;
    assign ev[EV_UV] = sns.uv && !uv_q_r;
    assign ev[EV_READY] = turn_done && (state_nxt == ST_RUN);
    wire [EV_W-1:0] w1c = wr_stat ? wdata_r[EV_W-1:0] : EV_RESET;
    wire [EV_W-1:0] irq_stat_nxt = (irq_stat_r & ~w1c) | ev;
    wire [EV_W-1:0] irq_mask_nxt = wr_mask ? wdata_r[EV_W-1:0] : irq_mask_r;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irq_stat_r <= EV_RESET;
            irq_mask_r <= EV_RESET;
            irq <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    // Read path.
    // Status shows the synchronised inputs, two cycles behind the pins.
    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[STAT_STATE_LSB +: 4] = state_r;
        status_word[STAT_HP] = sns.hp_sense;
        status_word[STAT_UV] = sns.uv;
        status_word[STAT_THERM] = therm_r;
        status_word[STAT_FAULT] = sns.fault;
        status_word[STAT_DRIVE] = gate_drive_en;
        status_word[STAT_MUTED] = audio_mute;
    end

    wire rd_mode = (s_axi_araddr == OFS_MODE) || (s_axi_araddr == OFS_CBYTE);
    wire [31:0] rd_word =
        rd_mode ? {30'h0, mode_r} :
        (s_axi_araddr == OFS_STATUS) ? status_word :
        (s_axi_araddr == OFS_IRQ_STAT) ? {28'h0, irq_stat_r} :
        (s_axi_araddr == OFS_IRQ_MASK) ? {28'h0, irq_mask_r} : 32'h0;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !rvalid_nxt;
            s_axi_rvalid <= rvalid_nxt;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end
endmodule

// [src/amp_pkg.sv]
/*
 * Shared constants, types and the register map of the amplifier mode and protection controller.
 * Assumes a single 125 MHz clock and AXI4-Lite access with 32-bit data.
 */
package amp_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CBYTE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;

    localparam int MODE_RUN_BIT = 0;
    localparam int MODE_UNMUTE_BIT = 1;
    localparam int MODE_W = 2;
    localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;
    localparam int CBYTE_SEL_BIT = 7;

    localparam int EV_FAULT = 0;
    localparam int EV_THERM = 1;
    localparam int EV_UV = 2;
    localparam int EV_READY = 3;
    localparam int EV_W = 4;
    localparam logic [EV_W-1:0] EV_RESET = 4'h0;

    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_HP = 4;
    localparam int STAT_UV = 5;
    localparam int STAT_THERM = 6;
    localparam int STAT_FAULT = 7;
    localparam int STAT_DRIVE = 8;
    localparam int STAT_MUTED = 9;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS_DEF = MS_NS / CLK_NS;
    localparam int TURN_ON_MS = 600;
    localparam int FAULT_HOLD_MS = 600;
    localparam int SW_FREQ_KHZ = 450;
    localparam int PWM_PERIOD_DEF = (MS_NS / CLK_NS) / SW_FREQ_KHZ;
    localparam int DUTY_MAX_PCT = 95;
    localparam int DUTY_W = 8;

    typedef enum logic [3:0] {
        ST_SHDN = 4'b0001,
        ST_TURNON = 4'b0010,
        ST_RUN = 4'b0100,
        ST_FAULT = 4'b1000
    } amp_state_t;

    typedef struct packed {
        logic hp_sense;
        logic uv;
        logic fault;
        logic temp_hi;
        logic temp_below_lo;
    } sense_t;
endpackage

// [src/pwm_gen.sv]
/*
 * Fixed-frequency complementary switching waveform with a clamped peak duty.
 * Assumes duty_in comes from logic on mclk; run gates both outputs low.
 */
`timescale 1ns/1ns
module pwm_gen
    import amp_pkg::*;
#(
    parameter int PERIOD = PWM_PERIOD_DEF,
    parameter int MAX_PCT = DUTY_MAX_PCT
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [DUTY_W-1:0] duty_in,
    output logic out_p,
    output logic out_n
);
    localparam int CNT_W = $clog2(PERIOD);
    localparam int PROD_W = CNT_W + DUTY_W;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'((PERIOD * MAX_PCT) / 100);

    generate
        if (PERIOD < 4 || MAX_PCT < 1 || MAX_PCT > 99) begin : g_chk
            $error("pwm_gen period or duty limit out of range");
        end
    endgenerate

    logic [CNT_W-1:0] cnt_r;
    wire [PROD_W-1:0] prod = PROD_W'(duty_in) * PROD_W'(PERIOD);
    wire [CNT_W-1:0] thr_raw = prod[PROD_W-1:DUTY_W];
    // Clamp keeps the opposite phase from ever vanishing.
    wire [CNT_W-1:0] thr = (thr_raw > LIMIT) ? LIMIT : thr_raw;
    wire high_phase = cnt_r < thr;

    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            cnt_r <= '0;
            out_p <= 1'b0;
            out_n <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
            out_p <= high_phase;
            out_n <= !high_phase;
        end
    end
endmodule

// [src/sync_bits.sv]
/*
 * Two-stage synchroniser for a group of asynchronous level inputs.
 * Assumes each input is a slow level; no bus coherence between bits is given.
 */
`timescale 1ns/1ns
module sync_bits #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    generate
        if (W < 1) begin : g_chk
            $error("sync_bits width must be at least one");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    meta_r[i] <= 1'b0;
                    dout[i] <= 1'b0;
                end else begin
                    meta_r[i] <= din[i];
                    dout[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule

// [tb/amp_mode_protect_checker.sv]
/*
 * Concurrent checks on the mode and protection outputs of amp_mode_protect_ctrl.
 * Assumes it is bound to that module and sees only its ports.
 */
`timescale 1ns/1ns
module amp_mode_protect_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic headphone_sense_input,
    input wire logic supply_under_voltage,
    input wire logic soa_fault,
    input wire logic temp_above_upper,
    input wire logic gate_drive_en,
    input wire logic speaker_en,
    input wire logic headphone_en,
    input wire logic audio_mute,
    input wire logic low_power,
    input wire logic pwm_out_p,
    input wire logic pwm_out_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_por_state: assert property ($rose(nrst) |-> low_power && audio_mute && !gate_drive_en)
        else $error("outputs not quiet after reset");
    a_shdn_quiet: assert property (low_power |-> audio_mute && !gate_drive_en && !speaker_en)
        else $error("drive or sound during shutdown");
    a_hp_always: assert property (headphone_en)
        else $error("headphone stage disabled");
    a_spk_sense: assert property (headphone_sense_input [*4] |=> !speaker_en)
        else $error("speaker on with headphones in");
    a_uv_off: assert property (supply_under_voltage [*4] |=> !gate_drive_en)
        else $error("drive on under low supply");
    a_therm_off: assert property (temp_above_upper [*4] |=> !gate_drive_en)
        else $error("drive on while hot");
    a_fault_cut: assert property ($rose(soa_fault) && gate_drive_en |-> ##[1:5] !gate_drive_en)
        else $error("fault did not cut drive");
    a_turnon_mute: assert property ($fell(low_power) |-> audio_mute [*8] ##0 !gate_drive_en)
        else $error("not muted at turn-on");
    a_pwm_compl: assert property (speaker_en && $past(speaker_en) |-> pwm_out_p != pwm_out_n)
        else $error("switching outputs not complementary");
endmodule

bind amp_mode_protect_ctrl amp_mode_protect_checker u_chk (
    .mclk(mclk), .nrst(nrst), .headphone_sense_input(headphone_sense_input),
    .supply_under_voltage(supply_under_voltage), .soa_fault(soa_fault),
    .temp_above_upper(temp_above_upper), .gate_drive_en(gate_drive_en),
    .speaker_en(speaker_en), .headphone_en(headphone_en), .audio_mute(audio_mute),
    .low_power(low_power), .pwm_out_p(pwm_out_p), .pwm_out_n(pwm_out_n)
);

// [tb/axi_host.sv]
/*
 * Host controller model that writes and reads the mode registers over AXI4-Lite.
 * Assumes one clock; hung rises when the slave never answers.
 */
`timescale 1ns/1ns
module axi_host
    import amp_pkg::*;
(
    input wire logic mclk,
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic hung
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, hung} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
    end

    // Only called once the supply is up; resp 3 marks no answer.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
        resp = 2'h3;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'b111;
        for (int n = 0; n < 100 && resp === 2'h3; n++) begin
            @(posedge mclk);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
            if (bvalid) resp = bresp;
        end
        bready <= 1'b0;
        hung <= hung || resp === 2'h3;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
        resp = 2'h3;
        d = '0;
        @(posedge mclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (int n = 0; n < 100 && resp === 2'h3; n++) begin
            @(posedge mclk);
            arvalid <= arvalid && !arready;
            if (rvalid) {d, resp} = {rdata, rresp};
        end
        rready <= 1'b0;
        hung <= hung || resp === 2'h3;
    endtask
endmodule

// [tb/test_amp_mode_protect_ctrl.sv]
/*
 * Self-checking bench for amp_mode_protect_ctrl driven through the host model.
 * Assumes shortened timer parameters so that every delay takes tens of cycles.
 */
`timescale 1ns/1ns
module test_amp_mode_protect_ctrl
    import amp_pkg::*;
;
    localparam int CYC = 10;
    localparam int TON = 3;
    localparam int HLD = 3;
    localparam int PER = 40;
    logic mclk, nrst, hp, uv, flt, thot, tcool, hung;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [DUTY_W-1:0] duty;
    logic gate, spk, hpen, mute, lowp, pp, pn, irq;
    int num_errors, compares;

    amp_mode_protect_ctrl #(.CYC_PER_MS(CYC), .TURN_MS(TON), .HOLD_MS(HLD), .PWM_PERIOD(PER)) u_dut (
        .mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .headphone_sense_input(hp), .supply_under_voltage(uv), .soa_fault(flt),
        .temp_above_upper(thot), .temp_below_lower(tcool), .audio_duty(duty),
        .gate_drive_en(gate), .speaker_en(spk), .headphone_en(hpen), .audio_mute(mute),
        .low_power(lowp), .pwm_out_p(pp), .pwm_out_n(pn), .irq(irq)
    );

    axi_host u_host (
        .mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .hung(hung)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected high time of one switching period, clamped so the low phase never vanishes.
    function automatic int exp_hi(input logic [7:0] d);
        int h;
        h = int'(d) * PER / (1 << DUTY_W);
        return (h > PER * DUTY_MAX_PCT / 100) ? PER * DUTY_MAX_PCT / 100 : h;
    endfunction

    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        num_errors++;
        $display("[ERR] %0t timeout %s", $time, what);
        end_of_test();
    endtask

    always @(posedge hung) give_up("bus");

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_drive(input logic lvl, input logic mchk, output int n);
        for (n = 0; n < 2000 && gate !== lvl; n++) begin
            if (mchk) chk(mute, 1'b1, "mute in turn-on");
            @(posedge mclk);
        end
        if (n == 2000) give_up("drive");
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        u_host.wr(a, d, r);
        chk(r, er, "bresp");
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        u_host.rd(a, d, r);
        chk(d, ed, "rdata");
        chk(r, er, "rresp");
    endtask

    task automatic pwm_meas(output int hi, output int per);
        int t;
        for (t = 0; t < 400 && pp !== 1'b0; t++) @(posedge mclk);
        for (; t < 400 && pp !== 1'b1; t++) @(posedge mclk);
        for (hi = 0; t < 400 && pp === 1'b1; t++, hi++) @(posedge mclk);
        for (per = hi; t < 400 && pp !== 1'b1; t++, per++) @(posedge mclk);
        if (t == 400) give_up("pwm");
    endtask

    initial begin
        int n, h, p;
        logic [31:0] d;
        logic [1:0] r;
        seed = 32'h36634CCF;
        {num_errors, compares} = '0;
        {nrst, hp, uv, flt, thot} = '0;
        tcool = 1'b1;
        duty = 8'h80;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        chk({lowp, mute, gate, hpen}, 4'b1101, "power-on outputs");
        rd(OFS_MODE, {30'h0, MODE_RESET}, RESP_OKAY);
        rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        wr(8'h40, 32'h3, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(OFS_CBYTE, 32'h3, RESP_OKAY);
        wait_drive(1'b1, 1'b1, n);
        chk(n >= (TON - 1) * CYC - 3 && n <= TON * CYC + 6, 1, "turn-on delay");
        wr(OFS_CBYTE, 32'h81, RESP_OKAY);
        rd(OFS_MODE, 32'h3, RESP_OKAY);
        repeat (4) @(posedge mclk);
        chk(mute, 1'b0, "unmuted");
        wr(OFS_MODE, 32'h1, RESP_OKAY);
        repeat (4) @(posedge mclk);
        chk({mute, gate}, 2'b11, "muted, drive kept");
        rd(OFS_STATUS, 32'(ST_RUN) | 32'h1 << STAT_DRIVE | 32'h1 << STAT_MUTED, RESP_OKAY);
        wr(OFS_MODE, 32'h3, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            d = xs();
            duty <= (i == 0) ? 8'hFF : (8'h20 | d[7:0]);
            repeat (PER + 3) @(posedge mclk);
            pwm_meas(h, p);
            chk(p, PER, "pwm period");
            chk(h, exp_hi(duty), "pwm high time");
        end
        hp <= 1'b1;
        repeat (6) @(posedge mclk);
        chk({spk, hpen, gate}, 3'b011, "headphone mode");
        hp <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(spk, 1'b1, "speaker mode");
        wr(OFS_IRQ_STAT, 32'hF, RESP_OKAY);
        flt <= 1'b1;
        wait_drive(1'b0, 1'b0, n);
        chk(n <= 5, 1, "fault cut");
        flt <= 1'b0;
        wait_drive(1'b1, 1'b0, n);
        chk(n >= (HLD - 1) * CYC - 3 && n <= HLD * CYC + 6, 1, "fault hold");
        u_host.rd(OFS_IRQ_STAT, d, r);
        chk(d[EV_FAULT], 1'b1, "fault event");
        chk(irq, 1'b0, "masked irq");
        wr(OFS_IRQ_MASK, 32'h1 << EV_FAULT, RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1, "irq raised");
        wr(OFS_IRQ_STAT, 32'h1 << EV_FAULT, RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0, "irq cleared");
        flt <= 1'b1;
        wait_drive(1'b0, 1'b0, n);
        wait_drive(1'b1, 1'b0, n);
        wait_drive(1'b0, 1'b0, n);
        chk(n <= 4, 1, "fault again");
        flt <= 1'b0;
        wait_drive(1'b1, 1'b0, n);
        chk(n >= (HLD - 1) * CYC - 3, 1, "hold restarted");
        {thot, tcool} <= 2'b10;
        wait_drive(1'b0, 1'b0, n);
        repeat (4) @(posedge mclk);
        thot <= 1'b0;
        repeat (40) @(posedge mclk);
        chk(gate, 1'b0, "thermal hysteresis");
        tcool <= 1'b1;
        wait_drive(1'b1, 1'b0, n);
        chk(n <= 6, 1, "thermal release");
        uv <= 1'b1;
        wait_drive(1'b0, 1'b0, n);
        chk(n <= 5, 1, "uv off");
        repeat (4) @(posedge mclk);
        uv <= 1'b0;
        wait_drive(1'b1, 1'b1, n);
        chk(n >= (TON - 1) * CYC - 3, 1, "uv turn-on");
        wr(OFS_MODE, 32'h2, RESP_OKAY);
        repeat (4) @(posedge mclk);
        chk({lowp, mute, gate, spk}, 4'b1100, "shutdown");
        wr(OFS_MODE, 32'h3, RESP_OKAY);
        wait_drive(1'b1, 1'b1, n);
        chk(n >= (TON - 1) * CYC - 3 && n <= TON * CYC + 6, 1, "wake delay");
        end_of_test();
    end
endmodule
